//--- hdl/rpd_pkg.sv
// rpd_pkg: constants and types shared by the reset and power-down block
// assumes a 250 MHz system clock and a register port with 8-bit data
package rpd_pkg;

   localparam int          CLK_MHZ          = 250;
   localparam int          RST_MIN_NS       = 1000;
   localparam int          RST_MIN_CYC      = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int          SYNC_STAGES      = 2;
   localparam logic [7:0]  PWR_CTRL_ADDR    = 8'h40;
   localparam int          PWR_RX_BIT       = 7;
   localparam int          PWR_ADC_BIT      = 6;
   localparam int          PWR_TX_BIT       = 5;
   localparam int          PWR_COAX_BIT     = 4;
   localparam int          PWR_OSC_BIT      = 3;
   localparam logic [7:0]  PWR_CTRL_MASK    = 8'hF8;
   // bit set = module running; coax amplifier starts powered down
   localparam logic [7:0]  PWR_CTRL_RESET   = 8'hE8;
   localparam int          MPIO_GROUP_W     = 4;
   localparam int          MPO_W            = 2;

   typedef struct packed {
      logic       receiverOn;
      logic       converterOn;
      logic       transmitterOn;
      logic       coaxAmpOn;
      logic       oscillatorOn;
   } rpd_power_s;

   typedef struct packed {
      logic       sysClock;
      logic       bitClock;
      logic       wordClock;
      logic       data;
   } rpd_main_port_s;

endpackage

//--- hdl/rpd_reset_sync.sv
// rpd_reset_sync: asserts reset at once, releases it after a clocked chain
// assumes clk_sys keeps running while either reset source is active
`timescale 1ns/100ps
`default_nettype none
module rpd_reset_sync #(
   parameter int STAGES = 2
) (
   input  wire logic clk_sys,
   input  wire logic resetReq,
   output var  logic resetOut
);
   logic [STAGES-1:0] chain;

   always_ff @(posedge clk_sys or posedge resetReq) begin
      if (resetReq) begin
         chain <= '1;
      end else begin
         chain <= {chain[STAGES-2:0], 1'b0};
      end
   end

   assign resetOut = chain[STAGES-1];
endmodule
`default_nettype wire

//--- hdl/rpd_reset_power_ctrl.sv
// rpd_reset_power_ctrl: merges power-on and pin reset, holds the power
// control register and forces the documented pin states during reset
// assumes por_n comes from the supply monitor and rst_n from the board pin
`timescale 1ns/100ps
`default_nettype none
// Function
// - pin low puts device fully powered down
// - reset returns all configuration to defaults
// - defaults: all on, coax amp off
// - power register gates modules, keeps settings
// - either reset source alone initialises device
// - supply monitor threshold starts initialisation
// - main port and outputs low, flags fixed
// - io pins released, crystal runs, coax high
module rpd_reset_power_ctrl
   import rpd_pkg::*;
#(
   parameter int MPIO_W = MPIO_GROUP_W
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 por_n,
   input  wire logic                 regWrite,
   input  wire logic                 regRead,
   input  wire logic [7:0]           regAddr,
   input  wire logic [7:0]           regWdata,
   output var  logic [7:0]           regRdata,
   output var  logic                 deviceInReset,
   output var  rpd_power_s           modulePower,
   input  wire rpd_main_port_s       mainPortIn,
   input  wire logic                 faultIn,
   input  wire logic                 compressedIn,
   input  wire logic [MPO_W-1:0]     mpoIn,
   input  wire logic [3*MPIO_W-1:0]  mpioOutIn,
   input  wire logic [3*MPIO_W-1:0]  mpioOeIn,
   input  wire logic                 ctrlInOut,
   input  wire logic                 ctrlInOe,
   input  wire logic                 ctrlOutOut,
   input  wire logic                 ctrlOutOe,
   input  wire logic                 crystalDriveIn,
   input  wire logic [1:0]           coaxBiasIn,
   output var  rpd_main_port_s       mainPortOut,
   output var  logic                 faultFlagIrqA,
   output var  logic                 compressedFlagIrqB,
   output var  logic [MPO_W-1:0]     multipurposeOutput,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupAOut,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupAOe,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupBOut,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupBOe,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupCOut,
   output var  logic [MPIO_W-1:0]    multipurposeIoGroupCOe,
   output var  logic                 controlSerialInOut,
   output var  logic                 controlSerialInOe,
   output var  logic                 controlSerialOutOut,
   output var  logic                 controlSerialOutOe,
   output var  logic                 crystalDriveOut,
   output var  logic [1:0]           coaxInput
);
   logic       resetRequest;
   logic       inReset;
   logic [7:0] powerCtrl;
   logic [7:0] next_powerCtrl;
   logic       powerHit;
   logic       rdHit;
   logic [7:0]            next_regRdata;
   rpd_main_port_s        next_mainPortOut;
   logic                  next_faultFlagIrqA;
   logic                  next_compressedFlagIrqB;
   logic [MPO_W-1:0]      next_multipurposeOutput;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupAOut;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupAOe;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupBOut;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupBOe;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupCOut;
   logic [MPIO_W-1:0]     next_multipurposeIoGroupCOe;
   logic                  next_controlSerialInOut;
   logic                  next_controlSerialInOe;
   logic                  next_controlSerialOutOut;
   logic                  next_controlSerialOutOe;

   // levels that the pins take while the device sits in reset
   localparam logic [7:0]        RDATA_IDLE       = 8'h00;
   localparam rpd_main_port_s    MAIN_PORT_RESET  = '0;
   localparam logic              FAULT_RESET      = 1'b1;
   localparam logic              COMPRESSED_RESET = 1'b0;
   localparam logic [MPO_W-1:0]  MPO_RESET        = '0;
   localparam logic [MPIO_W-1:0] MPIO_RELEASED    = '0;
   localparam logic              PIN_RELEASED     = 1'b0;
   localparam logic [1:0]        COAX_RESET       = 2'h3;

   // either source resets; por_n low until supply passes threshold
   // pin low forces reset; pulse width is the host's duty
   assign resetRequest = ~rst_n | ~por_n;

   rpd_reset_sync #(
      .STAGES   (SYNC_STAGES)
   ) u_sync (
      .clk_sys  (clk_sys),
      .resetReq (resetRequest),
      .resetOut (inReset)
   );

   // unused low bits are masked so they always read as zero
   assign powerHit       = regWrite & (regAddr == PWR_CTRL_ADDR);
   assign rdHit          = regRead & (regAddr == PWR_CTRL_ADDR);
   assign next_powerCtrl = powerHit ? (regWdata & PWR_CTRL_MASK) : powerCtrl;
   // read data idles at zero so an unaddressed read is harmless
   assign next_regRdata  = (rdHit & ~inReset) ? powerCtrl : RDATA_IDLE;

   // defaults restored in reset; writes touch nothing else
   always_ff @(posedge clk_sys) begin
      if (inReset) begin
         powerCtrl <= PWR_CTRL_RESET;
      end else begin
         powerCtrl <= next_powerCtrl;
      end
   end

   // one cycle of read latency; the data stands for as many cycles as the read is held
   always_ff @(posedge clk_sys) begin
      regRdata <= next_regRdata;
   end

   assign deviceInReset = inReset;

   // whole device down in reset, else per-module enables
   assign modulePower.receiverOn    = ~inReset & powerCtrl[PWR_RX_BIT];
   assign modulePower.converterOn   = ~inReset & powerCtrl[PWR_ADC_BIT];
   assign modulePower.transmitterOn = ~inReset & powerCtrl[PWR_TX_BIT];
   assign modulePower.coaxAmpOn     = ~inReset & powerCtrl[PWR_COAX_BIT];
   assign modulePower.oscillatorOn  = ~inReset & powerCtrl[PWR_OSC_BIT];

   // fixed levels on main port, flags and multipurpose outputs
   // levels are chosen ahead of the flops so the pins never glitch
   assign next_mainPortOut        = inReset ? MAIN_PORT_RESET  : mainPortIn;
   assign next_faultFlagIrqA      = inReset ? FAULT_RESET      : faultIn;
   assign next_compressedFlagIrqB = inReset ? COMPRESSED_RESET : compressedIn;
   assign next_multipurposeOutput = inReset ? MPO_RESET        : mpoIn;

   always_ff @(posedge clk_sys) begin
      mainPortOut <= next_mainPortOut;
   end

   always_ff @(posedge clk_sys) begin
      faultFlagIrqA <= next_faultFlagIrqA;
   end

   always_ff @(posedge clk_sys) begin
      compressedFlagIrqB <= next_compressedFlagIrqB;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeOutput <= next_multipurposeOutput;
   end

   // multipurpose and serial-control pins released during reset
   // enables low in reset leave the pins floating for the board
   assign next_multipurposeIoGroupAOut = inReset ? MPIO_RELEASED : mpioOutIn[MPIO_W-1:0];
   assign next_multipurposeIoGroupAOe  = inReset ? MPIO_RELEASED : mpioOeIn[MPIO_W-1:0];
   assign next_multipurposeIoGroupBOut = inReset ? MPIO_RELEASED : mpioOutIn[2*MPIO_W-1:MPIO_W];
   assign next_multipurposeIoGroupBOe  = inReset ? MPIO_RELEASED : mpioOeIn[2*MPIO_W-1:MPIO_W];
   assign next_multipurposeIoGroupCOut = inReset ? MPIO_RELEASED : mpioOutIn[3*MPIO_W-1:2*MPIO_W];
   assign next_multipurposeIoGroupCOe  = inReset ? MPIO_RELEASED : mpioOeIn[3*MPIO_W-1:2*MPIO_W];
   assign next_controlSerialInOut      = inReset ? PIN_RELEASED  : ctrlInOut;
   assign next_controlSerialInOe       = inReset ? PIN_RELEASED  : ctrlInOe;
   assign next_controlSerialOutOut     = inReset ? PIN_RELEASED  : ctrlOutOut;
   assign next_controlSerialOutOe      = inReset ? PIN_RELEASED  : ctrlOutOe;

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupAOut <= next_multipurposeIoGroupAOut;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupAOe <= next_multipurposeIoGroupAOe;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupBOut <= next_multipurposeIoGroupBOut;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupBOe <= next_multipurposeIoGroupBOe;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupCOut <= next_multipurposeIoGroupCOut;
   end

   always_ff @(posedge clk_sys) begin
      multipurposeIoGroupCOe <= next_multipurposeIoGroupCOe;
   end

   // serial-control pins stay released until the core asks for them
   always_ff @(posedge clk_sys) begin
      controlSerialInOut <= next_controlSerialInOut;
   end

   always_ff @(posedge clk_sys) begin
      controlSerialInOe <= next_controlSerialInOe;
   end

   always_ff @(posedge clk_sys) begin
      controlSerialOutOut <= next_controlSerialOutOut;
   end

   always_ff @(posedge clk_sys) begin
      controlSerialOutOe <= next_controlSerialOutOe;
   end

   // crystal drive stays live; coax inputs sit high in reset
   // the crystal path is combinational so crystal drive never stops, even in reset
   assign crystalDriveOut = crystalDriveIn;
   // limitation: the coax level follows the bias input with no latency
   assign coaxInput       = inReset ? COAX_RESET : coaxBiasIn;
endmodule
`default_nettype wire

//--- test/rpd_reset_power_ctrl_asserts.sv
// checker: reset states and power register relations at the block's ports
// assumes it is bound into rpd_reset_power_ctrl
`timescale 1ns/100ps
`default_nettype none
module rpd_reset_power_ctrl_asserts
   import rpd_pkg::*;
#(
   parameter int MPIO_W = MPIO_GROUP_W
) (
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              por_n,
   input wire logic              regWrite,
   input wire logic              regRead,
   input wire logic [7:0]        regAddr,
   input wire logic [7:0]        regWdata,
   input wire logic [7:0]        regRdata,
   input wire logic              deviceInReset,
   input wire rpd_power_s        modulePower,
   input wire rpd_main_port_s    mainPortOut,
   input wire logic              faultFlagIrqA,
   input wire logic              compressedFlagIrqB,
   input wire logic [MPO_W-1:0]  multipurposeOutput,
   input wire logic [MPIO_W-1:0] multipurposeIoGroupAOe,
   input wire logic [MPIO_W-1:0] multipurposeIoGroupBOe,
   input wire logic [MPIO_W-1:0] multipurposeIoGroupCOe,
   input wire logic              controlSerialInOe,
   input wire logic              controlSerialOutOe,
   input wire logic [1:0]        coaxInput
);
   default clocking @(posedge clk_sys); endclocking
   // only por_n disables, so the pin-reset window stays under check
   default disable iff (!por_n);
   sequence held; deviceInReset && $past(deviceInReset); endsequence
   sequence wr40; regWrite && regAddr == 8'h40 && !deviceInReset; endsequence
   sequence rd40; regRead && regAddr == 8'h40 && !deviceInReset; endsequence
   a_pin_enter: assert property (!rst_n |-> deviceInReset && modulePower == 5'h00)
      else $error("pin reset not entered");
   a_out_hold: assert property (held |-> mainPortOut == 4'h0 && faultFlagIrqA
      && !compressedFlagIrqB && multipurposeOutput == '0) else $error("outputs not forced");
   a_pins_float: assert property (held |-> coaxInput == 2'h3 && !(|{controlSerialInOe,
      controlSerialOutOe, multipurposeIoGroupAOe, multipurposeIoGroupBOe,
      multipurposeIoGroupCOe})) else $error("pins not released");
   a_sync_release: assert property ((rst_n && por_n) [*3] |-> !deviceInReset)
      else $error("release late");
   a_reset_default: assert property ($fell(deviceInReset) |-> $past(rst_n && por_n, 2)
      && modulePower == 5'h1D) else $error("bad release or default");
   a_write_effect: assert property (wr40 ##1 !deviceInReset
      |-> modulePower == $past(regWdata[7:3])) else $error("write lost");
   a_read_back: assert property (rd40 |=> regRdata == {$past(modulePower), 3'h0})
      else $error("read wrong");
   a_other_addr: assert property (regRead && regAddr != 8'h40 |=> regRdata == 8'h00)
      else $error("unmapped read");
endmodule
bind rpd_reset_power_ctrl rpd_reset_power_ctrl_asserts #(.MPIO_W(MPIO_W)) chk_u (.*);
`default_nettype wire

//--- test/rpd_host_model.sv
// host model: board supervisor driving the reset pin
// assumes a free-running clk_sys
`timescale 1ns/100ps
`default_nettype none
module rpd_host_model (
   input wire logic clk_sys,
   output var logic rst_n
);
   initial rst_n = 1'h1;
   task automatic pulse(input int n);
      @(posedge clk_sys) rst_n <= 1'h0;
      repeat (n) @(posedge clk_sys);
      rst_n <= 1'h1;
   endtask
endmodule
`default_nettype wire

//--- test/reset_and_power_down_control_tb_top.sv
// testbench: power register traffic, pin and power-on reset
// assumes rpd_pkg and the host model for the reset pin
`timescale 1ns/100ps
`default_nettype none
module reset_and_power_down_control_tb_top;
   import rpd_pkg::*;
   logic clk_sys = 1'h0, por_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, rst_n;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
   rpd_main_port_s mainPortIn, mainPortOut;
   rpd_power_s modulePower;
   logic faultIn, compressedIn, ctrlInOut, ctrlInOe, ctrlOutOut, ctrlOutOe, crystalDriveIn;
   logic [1:0] mpoIn, coaxBiasIn, coaxInput, multipurposeOutput;
   logic [11:0] mpioOutIn, mpioOeIn;
   logic [3:0] multipurposeIoGroupAOut, multipurposeIoGroupAOe, multipurposeIoGroupBOut;
   logic [3:0] multipurposeIoGroupBOe, multipurposeIoGroupCOut, multipurposeIoGroupCOe;
   logic deviceInReset, faultFlagIrqA, compressedFlagIrqB, controlSerialInOut;
   logic controlSerialInOe, controlSerialOutOut, controlSerialOutOe, crystalDriveOut;
   int errors = 0, n_tests = 0, cyc = 0;
   // fault input low so the forced high flag in reset is visible
   logic [38:0] core = 39'h7BFFFFFFFF;
   // address, write data, read data, powered modules
   logic [7:0] rows [4][4] = '{'{8'h40, 8'h10, 8'h10, 8'h10}, '{8'h40, 8'hFF, 8'hF8, 8'hF8},
      '{8'h41, 8'h00, 8'h00, 8'hF8}, '{8'h40, 8'h07, 8'h00, 8'h00}};
   assign {mainPortIn, faultIn, compressedIn, mpoIn, mpioOutIn, mpioOeIn, ctrlInOut, ctrlInOe,
      ctrlOutOut, ctrlOutOe, crystalDriveIn, coaxBiasIn} = core;
   rpd_reset_power_ctrl dut_u (.*);
   rpd_host_model host_u (.*);
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors = errors + 1;
         end_of_test;
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge clk_sys);
      regWrite <= w;
      regRead <= !w;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'h0;
      regRead <= 1'h0;
      #1;
   endtask
   task automatic wait_out;
      while (deviceInReset !== 1'h0) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      por_n <= 1'h1;
      wait_out;
      chk("fault", faultFlagIrqA, 8'h01);
      @(posedge clk_sys);
      #1;
      chk("fault", faultFlagIrqA, 8'h00);
      chk("compressed", compressedFlagIrqB, 8'h01);
      chk("main", mainPortOut, 8'h0F);
      chk("mpo", multipurposeOutput, 8'h03);
      chk("mpio", {multipurposeIoGroupAOut, multipurposeIoGroupCOe}, 8'hFF);
      chk("ctrl", {controlSerialInOut, controlSerialOutOut, crystalDriveOut}, 8'h07);
      for (int i = 0; i < 4; i++) begin
         acc(1'h1, rows[i][0], rows[i][1]);
         chk("power", modulePower, rows[i][3] >> 3);
         acc(1'h0, rows[i][0], 8'h00);
         chk("rdata", regRdata, rows[i][2]);
         $display("row %0d done", i);
      end
      fork host_u.pulse(RST_MIN_CYC); join_none
      repeat (5) @(posedge clk_sys);
      #1;
      chk("fault", faultFlagIrqA, 8'h01);
      chk("main", mainPortOut, 8'h00);
      chk("coax", coaxInput, 8'h03);
      chk("oe", {multipurposeIoGroupBOe, controlSerialOutOe}, 8'h00);
      chk("power", modulePower, 8'h00);
      chk("compressed", compressedFlagIrqB, 8'h00);
      chk("mpo", multipurposeOutput, 8'h00);
      chk("oeac", {multipurposeIoGroupAOe, multipurposeIoGroupCOe}, 8'h00);
      chk("oein", controlSerialInOe, 8'h00);
      chk("xtal", crystalDriveOut, 8'h01);
      wait_out;
      acc(1'h0, 8'h40, 8'h00);
      chk("rdata", regRdata, 8'hE8);
      $display("pin reset done");
      acc(1'h1, 8'h40, 8'h00);
      @(posedge clk_sys);
      por_n <= 1'h0;
      acc(1'h1, 8'h40, 8'h10);
      @(posedge clk_sys);
      por_n <= 1'h1;
      wait_out;
      acc(1'h0, 8'h40, 8'h00);
      chk("rdata", regRdata, 8'hE8);
      $display("power-on reset done");
      @(posedge clk_sys);
      core <= ~core;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("fault", faultFlagIrqA, 8'h01);
      chk("coax", coaxInput, 8'h00);
      chk("xtal", crystalDriveOut, 8'h00);
      chk("main", mainPortOut, 8'h00);
      chk("compressed", compressedFlagIrqB, 8'h00);
      $display("pass-through done");
      end_of_test;
   end
endmodule
`default_nettype wire
